// ---- verilog/nvreg_pkg.sv ----
package nvreg_pkg;

    // ****************************************
    // Command codes
    // ****************************************
    localparam logic [7:0] CMD_SET_WRITE_LATCH  = 8'h06;
    localparam logic [7:0] CMD_CLR_WRITE_LATCH  = 8'h04;
    localparam logic [7:0] CMD_LEGACY_REG_WRITE = 8'h01;
    localparam logic [7:0] CMD_ADDR_REG_READ    = 8'h65;
    localparam logic [7:0] CMD_ADDR_REG_WRITE   = 8'h71;
    localparam logic [7:0] CMD_STATUS_ONE_READ  = 8'h05;
    localparam logic [7:0] CMD_SOFT_RESET       = 8'hf0;

    // ****************************************
    // Register addresses for addressed access
    // ****************************************
    localparam logic [23:0] ADDR_STATUS_ONE_NV   = 24'h000000;
    localparam logic [23:0] ADDR_STATUS_ONE_LIVE = 24'h800000;
    localparam logic [1:0]  ADDR_LAST_BYTE       = 2'h2;

    // ****************************************
    // Register widths
    // ****************************************
    localparam int REG_W          = 8;
    localparam int REGION_PROT_W  = 16;
    localparam int PASSWORD_W     = 64;
    localparam int POINTER_REG_W  = 32;

    // ****************************************
    // Status register one layout and values
    // ****************************************
    localparam int POS_REGISTER_LOCK      = 7;
    localparam int POS_PROTECT_GRANULAR   = 6;
    localparam int POS_PROTECT_ORIGIN     = 5;
    localparam int POS_RANGE_PROTECT_HI   = 4;
    localparam int POS_RANGE_PROTECT_LO   = 2;
    localparam int POS_WRITE_LATCH        = 1;
    localparam int POS_BUSY_FLAG          = 0;

    localparam logic [7:0] STATUS_ONE_NV_SHIP  = 8'h00;
    localparam logic [7:0] STATUS_ONE_USER_MSK = 8'hfc;
    localparam logic [7:0] STATUS_ONE_OTP_MSK  = 8'h00;
    localparam logic [7:0] NV_ERASED_VALUE     = 8'hff;
    localparam logic [7:0] UNMAPPED_READ_VALUE = 8'h00;

    // ****************************************
    // Non-volatile cell timing
    // ****************************************
    localparam int CLK_PERIOD_PS   = 25000;
    localparam int ERASE_TIME_NS   = 2000;
    localparam int PROGRAM_TIME_NS = 1000;
    localparam int ERASE_CYC   = (ERASE_TIME_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
    localparam int PROGRAM_CYC = (PROGRAM_TIME_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
    localparam int NV_CNT_W    = 8;

    // ****************************************
    // Carriers
    // ****************************************
    typedef struct packed {
        logic       register_lock_bit;
        logic       protect_granularity_bit;
        logic       protect_origin_bit;
        logic [2:0] range_protect;
        logic       write_latch;
        logic       busy_flag;
    } status_one_t;

    typedef struct packed {
        logic [7:0] data;
        logic       valid;
    } rx_byte_t;

endpackage

// ---- verilog/spi_byte_port.sv ----
`timescale 1ns/1ps
module spi_byte_port
    import nvreg_pkg::*;
(
    input  wire logic       i_clk,
    input  wire logic       i_rst,
    input  wire logic       i_sck,
    input  wire logic       i_cs_n,
    input  wire logic       i_si,
    input  wire logic       i_tx_load,
    input  wire logic [7:0] i_tx_byte,
    output rx_byte_t        o_rx,
    output logic            o_selected,
    output logic            o_deselect,
    output logic            o_so
);

    // ****************************************
    // Pin synchronisers
    // ****************************************
    logic [2:0] sck_ff;
    logic [2:0] cs_n_ff;
    logic [1:0] si_ff;
    logic [7:0] rx_sh_ff;
    logic [2:0] bit_cnt_ff;
    logic [7:0] tx_sh_ff;
    logic       so_ff;
    rx_byte_t   rx_ff;
    logic       desel_ff;
    logic [7:0] nxt_rx_sh;
    logic [2:0] nxt_bit_cnt;
    logic [7:0] nxt_tx_sh;
    logic       nxt_so;
    rx_byte_t   nxt_rx;
    logic       nxt_desel;
    logic       sck_rise;
    logic       sck_fall;
    logic       sel;

    assign sel      = ~cs_n_ff[1];
    assign sck_rise = sel & sck_ff[1] & ~sck_ff[2];
    assign sck_fall = sel & ~sck_ff[1] & sck_ff[2];

    // ****************************************
    // Shifting
    // ****************************************
    always_comb
    begin
        nxt_rx_sh   = rx_sh_ff;
        nxt_bit_cnt = bit_cnt_ff;
        nxt_tx_sh   = tx_sh_ff;
        nxt_so      = so_ff;
        nxt_rx      = '0;
        nxt_desel   = cs_n_ff[1] & ~cs_n_ff[2];
        if (!sel)
        begin
            nxt_bit_cnt = 3'h0;
        end
        else if (sck_rise)
        begin
            nxt_rx_sh   = {rx_sh_ff[6:0], si_ff[1]};
            nxt_bit_cnt = bit_cnt_ff + 3'h1;
            if (bit_cnt_ff == 3'h7)
            begin
                nxt_rx.data  = {rx_sh_ff[6:0], si_ff[1]};
                nxt_rx.valid = 1'b1;
            end
        end
        if (i_tx_load)
        begin
            nxt_tx_sh = i_tx_byte;
        end
        else if (sck_fall)
        begin
            nxt_so    = tx_sh_ff[7];
            nxt_tx_sh = {tx_sh_ff[6:0], 1'b0};
        end
    end

    always_ff @(posedge i_clk)
    begin
        if (i_rst)
        begin
            sck_ff     <= 3'h0;
            cs_n_ff    <= 3'h7;
            si_ff      <= 2'h0;
            rx_sh_ff   <= 8'h00;
            bit_cnt_ff <= 3'h0;
            tx_sh_ff   <= 8'h00;
            so_ff      <= 1'b0;
            rx_ff      <= '0;
            desel_ff   <= 1'b0;
        end
        else
        begin
            sck_ff     <= {sck_ff[1:0], i_sck};
            cs_n_ff    <= {cs_n_ff[1:0], i_cs_n};
            si_ff      <= {si_ff[0], i_si};
            rx_sh_ff   <= nxt_rx_sh;
            bit_cnt_ff <= nxt_bit_cnt;
            tx_sh_ff   <= nxt_tx_sh;
            so_ff      <= nxt_so;
            rx_ff      <= nxt_rx;
            desel_ff   <= nxt_desel;
        end
    end

    assign o_rx       = rx_ff;
    assign o_selected = sel;
    assign o_deselect = desel_ff;
    assign o_so       = so_ff;

endmodule

// ---- verilog/nv_byte_store.sv ----
`timescale 1ns/1ps
module nv_byte_store
    import nvreg_pkg::*;
(
    input  wire logic       i_clk,
    input  wire logic       i_por,
    input  wire logic       i_start,
    input  wire logic       i_otp_only,
    input  wire logic [7:0] i_data,
    output logic [7:0]      o_value,
    output logic            o_busy,
    output logic            o_done
);

    typedef enum logic [1:0] {
        NV_IDLE  = 2'b00,
        NV_ERASE = 2'b01,
        NV_PROG  = 2'b11,
        NV_DONE  = 2'b10
    } nv_state_t;

    nv_state_t           state_ff;
    nv_state_t           nxt_state;
    logic [7:0]          value_ff;
    logic [7:0]          nxt_value;
    logic [7:0]          data_ff;
    logic [7:0]          nxt_data;
    logic [NV_CNT_W-1:0] cnt_ff;
    logic [NV_CNT_W-1:0] nxt_cnt;

    // ****************************************
    // Erase then program sequence
    // ****************************************
    always_comb
    begin
        nxt_state = state_ff;
        nxt_value = value_ff;
        nxt_data  = data_ff;
        nxt_cnt   = cnt_ff;
        case (state_ff)
            NV_IDLE:
            begin
                if (i_start)
                begin
                    nxt_data = i_data;
                    if (i_otp_only)
                    begin
                        nxt_state = NV_PROG;
                        nxt_cnt   = NV_CNT_W'(PROGRAM_CYC - 1);
                    end
                    else
                    begin
                        nxt_state = NV_ERASE;
                        nxt_cnt   = NV_CNT_W'(ERASE_CYC - 1);
                    end
                end
            end
            NV_ERASE:
            begin
                if (cnt_ff == '0)
                begin
                    nxt_value = (value_ff & (STATUS_ONE_OTP_MSK | ~STATUS_ONE_USER_MSK))
                              | (NV_ERASED_VALUE & STATUS_ONE_USER_MSK
                                 & ~STATUS_ONE_OTP_MSK);
                    nxt_state = NV_PROG;
                    nxt_cnt   = NV_CNT_W'(PROGRAM_CYC - 1);
                end
                else
                begin
                    nxt_cnt = cnt_ff - 1'b1;
                end
            end
            NV_PROG:
            begin
                if (cnt_ff == '0)
                begin
                    nxt_value = (data_ff & ~STATUS_ONE_OTP_MSK)
                              | ((value_ff | data_ff) & STATUS_ONE_OTP_MSK);
                    nxt_state = NV_DONE;
                end
                else
                begin
                    nxt_cnt = cnt_ff - 1'b1;
                end
            end
            NV_DONE:
            begin
                nxt_state = NV_IDLE;
            end
            default:
            begin
                nxt_state = NV_IDLE;
            end
        endcase
    end

    always_ff @(posedge i_clk)
    begin
        if (i_por)
        begin
            state_ff <= NV_IDLE;
            value_ff <= STATUS_ONE_NV_SHIP;
            data_ff  <= 8'h00;
            cnt_ff   <= '0;
        end
        else
        begin
            state_ff <= nxt_state;
            value_ff <= nxt_value;
            data_ff  <= nxt_data;
            cnt_ff   <= nxt_cnt;
        end
    end

    assign o_value = value_ff;
    assign o_busy  = (state_ff != NV_IDLE);
    assign o_done  = (state_ff == NV_DONE);

endmodule

// ---- verilog/nv_shadow_status_register.sv ----
`timescale 1ns/1ps
// How it works
// - Code 05h and reads of the live address return the live copy; the non-volatile address returns the non-volatile copy.
// - Power-on, hardware and software reset reload the live copy from non-volatile.
// - Non-volatile writes erase, program, then refresh the live copy.
// - One-time bits program without erase and update the live copy.
// - Status one exists as a non-volatile and live pair.
// - Live bits take defaults after reset; non-volatile bits ship as factory values.
// - Bit 7 defaults the register lock bit; ships as 0.
// - Bit 6 defaults the protect granularity bit; ships as 0.
// - Bit 5 defaults the protect origin bit; ships as 0.
// - Bits 4 to 2 default the range protect bits; ship as zeros.
// - Bit 1 defaults the write latch; read-only, factory 0.
// - Bit 0 defaults the busy flag; read-only, factory 0.
// - Code 06h sets and 04h clears the write latch.
// - Codes 01h, 65h and 71h write, read and write the registers.
// - Region, password and pointer registers are 16, 64, 32 bits; others 8.
// - Code 05h returns the live status one copy.
module nv_shadow_status_register
    import nvreg_pkg::*;
(
    input  wire logic       i_clk,
    input  wire logic       i_rst,
    input  wire logic       i_por,
    input  wire logic       i_sck,
    input  wire logic       i_cs_n,
    input  wire logic       i_si,
    output logic            o_so,
    output logic [7:0]      o_live_status,
    output logic [7:0]      o_nv_status
);

    typedef enum logic [2:0] {
        S_IDLE = 3'b000,
        S_CMD  = 3'b001,
        S_ADDR = 3'b011,
        S_DATA = 3'b010,
        S_READ = 3'b110,
        S_SKIP = 3'b100
    } cmd_state_t;

    // ****************************************
    // Declarations
    // ****************************************
    rx_byte_t    rx;
    logic        selected;
    logic        deselect;
    logic [7:0]  nv_value;
    logic        nv_busy;
    logic        nv_done;

    cmd_state_t  state_ff;
    cmd_state_t  nxt_state;
    logic [7:0]  cmd_ff;
    logic [7:0]  nxt_cmd;
    logic [23:0] addr_ff;
    logic [23:0] nxt_addr;
    logic [1:0]  addr_cnt_ff;
    logic [1:0]  nxt_addr_cnt;
    logic [7:0]  wr_data_ff;
    logic [7:0]  nxt_wr_data;
    logic        wr_pend_ff;
    logic        nxt_wr_pend;
    status_one_t live_ff;
    status_one_t nxt_live;
    logic        reload_ff;
    logic        nxt_reload;
    logic        tx_load;
    logic [7:0]  tx_byte;
    logic        nv_start;
    logic        nv_otp_only;
    logic [7:0]  nv_new;
    logic [7:0]  nv_ff;

    // ****************************************
    // Helpers
    // ****************************************
    function automatic logic [7:0] read_select(input logic [23:0] addr,
                                               input logic [7:0]  nv,
                                               input logic [7:0]  live);
        logic [7:0] r;
        r = UNMAPPED_READ_VALUE;
        if (addr == ADDR_STATUS_ONE_LIVE)
        begin
            r = live;
        end
        else if (addr == ADDR_STATUS_ONE_NV)
        begin
            r = nv;
        end
        return r;
    endfunction

    function automatic status_one_t live_from_nv(input logic [7:0] nv);
        status_one_t s;
        s.register_lock_bit       = nv[POS_REGISTER_LOCK];
        s.protect_granularity_bit = nv[POS_PROTECT_GRANULAR];
        s.protect_origin_bit      = nv[POS_PROTECT_ORIGIN];
        s.range_protect           = nv[POS_RANGE_PROTECT_HI:POS_RANGE_PROTECT_LO];
        s.write_latch             = nv[POS_WRITE_LATCH];
        s.busy_flag               = nv[POS_BUSY_FLAG];
        return s;
    endfunction

    // ****************************************
    // Sub-blocks
    // ****************************************
    spi_byte_port u_port (
        .i_clk      (i_clk),
        .i_rst      (i_rst | i_por),
        .i_sck      (i_sck),
        .i_cs_n     (i_cs_n),
        .i_si       (i_si),
        .i_tx_load  (tx_load),
        .i_tx_byte  (tx_byte),
        .o_rx       (rx),
        .o_selected (selected),
        .o_deselect (deselect),
        .o_so       (o_so)
    );

    // Non-volatile half of the status one pair
    nv_byte_store u_nv (
        .i_clk      (i_clk),
        .i_por      (i_por),
        .i_start    (nv_start),
        .i_otp_only (nv_otp_only),
        .i_data     (nv_new),
        .o_value    (nv_value),
        .o_busy     (nv_busy),
        .o_done     (nv_done)
    );

    // Writable bits from host, read-only defaults kept
    assign nv_new      = (wr_data_ff & STATUS_ONE_USER_MSK)
                       | (nv_value & ~STATUS_ONE_USER_MSK);
    assign nv_otp_only = (((nv_new ^ nv_value) & ~STATUS_ONE_OTP_MSK) == 8'h00)
                       & (((nv_new ^ nv_value) & STATUS_ONE_OTP_MSK) != 8'h00);

    // ****************************************
    // Command decoder
    // ****************************************
    always_comb
    begin
        nxt_state    = state_ff;
        nxt_cmd      = cmd_ff;
        nxt_addr     = addr_ff;
        nxt_addr_cnt = addr_cnt_ff;
        nxt_wr_data  = wr_data_ff;
        nxt_wr_pend  = wr_pend_ff;
        nxt_live     = live_ff;
        nxt_reload   = 1'b0;
        tx_load      = 1'b0;
        tx_byte      = 8'h00;
        nv_start     = 1'b0;

        if (reload_ff)
        begin
            nxt_live = live_from_nv(nv_value);
        end

        if (nv_done)
        begin
            nxt_live                         = live_from_nv(nv_value);
            nxt_live.write_latch             = 1'b0;
            nxt_live.busy_flag               = 1'b0;
        end

        if (deselect)
        begin
            nxt_state   = S_IDLE;
            nxt_wr_pend = 1'b0;
            if (wr_pend_ff && live_ff.write_latch && !nv_busy && !live_ff.busy_flag)
            begin
                if (cmd_ff == CMD_ADDR_REG_WRITE && addr_ff == ADDR_STATUS_ONE_LIVE)
                begin
                    nxt_live.register_lock_bit       = wr_data_ff[POS_REGISTER_LOCK];
                    nxt_live.protect_granularity_bit = wr_data_ff[POS_PROTECT_GRANULAR];
                    nxt_live.protect_origin_bit      = wr_data_ff[POS_PROTECT_ORIGIN];
                    nxt_live.range_protect           =
                        wr_data_ff[POS_RANGE_PROTECT_HI:POS_RANGE_PROTECT_LO];
                    nxt_live.write_latch             = 1'b0;
                end
                else if (cmd_ff == CMD_LEGACY_REG_WRITE || addr_ff == ADDR_STATUS_ONE_NV)
                begin
                    nv_start           = 1'b1;
                    nxt_live.busy_flag = 1'b1;
                end
            end
        end
        else if (!selected)
        begin
            nxt_state = S_IDLE;
        end
        else
        begin
            case (state_ff)
                S_IDLE:
                begin
                    nxt_state    = S_CMD;
                    nxt_addr_cnt = 2'h0;
                end
                S_CMD:
                begin
                    if (rx.valid)
                    begin
                        nxt_cmd   = rx.data;
                        nxt_state = S_SKIP;
                        case (rx.data)
                            CMD_SET_WRITE_LATCH:
                            begin
                                if (!live_ff.busy_flag)
                                begin
                                    nxt_live.write_latch = 1'b1;
                                end
                            end
                            CMD_CLR_WRITE_LATCH:
                            begin
                                if (!live_ff.busy_flag)
                                begin
                                    nxt_live.write_latch = 1'b0;
                                end
                            end
                            CMD_STATUS_ONE_READ:
                            begin
                                nxt_addr  = ADDR_STATUS_ONE_LIVE;
                                tx_load   = 1'b1;
                                tx_byte   = read_select(ADDR_STATUS_ONE_LIVE, nv_value,
                                                        live_ff);
                                nxt_state = S_READ;
                            end
                            CMD_LEGACY_REG_WRITE:
                            begin
                                nxt_state = S_DATA;
                            end
                            CMD_ADDR_REG_READ:
                            begin
                                nxt_state = S_ADDR;
                            end
                            CMD_ADDR_REG_WRITE:
                            begin
                                nxt_state = S_ADDR;
                            end
                            CMD_SOFT_RESET:
                            begin
                                if (!live_ff.busy_flag)
                                begin
                                    nxt_reload = 1'b1;
                                end
                            end
                            default:
                            begin
                                nxt_state = S_SKIP;
                            end
                        endcase
                    end
                end
                S_ADDR:
                begin
                    if (rx.valid)
                    begin
                        nxt_addr     = {addr_ff[15:0], rx.data};
                        nxt_addr_cnt = addr_cnt_ff + 2'h1;
                        if (addr_cnt_ff == ADDR_LAST_BYTE)
                        begin
                            if (cmd_ff == CMD_ADDR_REG_READ)
                            begin
                                tx_load   = 1'b1;
                                tx_byte   = read_select({addr_ff[15:0], rx.data},
                                                        nv_value, live_ff);
                                nxt_state = S_READ;
                            end
                            else
                            begin
                                nxt_state = S_DATA;
                            end
                        end
                    end
                end
                S_DATA:
                begin
                    if (rx.valid)
                    begin
                        nxt_wr_data = rx.data;
                        nxt_wr_pend = 1'b1;
                        nxt_state   = S_SKIP;
                    end
                end
                S_READ:
                begin
                    if (rx.valid)
                    begin
                        tx_load = 1'b1;
                        tx_byte = read_select(addr_ff, nv_value, live_ff);
                    end
                end
                S_SKIP:
                begin
                    nxt_state = S_SKIP;
                end
                default:
                begin
                    nxt_state = S_IDLE;
                end
            endcase
        end
    end

    // ****************************************
    // State registers
    // ****************************************
    always_ff @(posedge i_clk)
    begin
        if (i_rst || i_por)
        begin
            state_ff    <= S_IDLE;
            cmd_ff      <= 8'h00;
            addr_ff     <= 24'h000000;
            addr_cnt_ff <= 2'h0;
            wr_data_ff  <= 8'h00;
            wr_pend_ff  <= 1'b0;
            live_ff     <= live_from_nv(STATUS_ONE_NV_SHIP);
            reload_ff   <= 1'b1;
            nv_ff       <= nv_value;
        end
        else
        begin
            state_ff    <= nxt_state;
            cmd_ff      <= nxt_cmd;
            addr_ff     <= nxt_addr;
            addr_cnt_ff <= nxt_addr_cnt;
            wr_data_ff  <= nxt_wr_data;
            wr_pend_ff  <= nxt_wr_pend;
            live_ff     <= nxt_live;
            reload_ff   <= nxt_reload;
            nv_ff       <= nv_value;
        end
    end

    assign o_live_status = live_ff;
    assign o_nv_status   = nv_ff;

endmodule

// ---- tb/nvreg_status_monitor.sv ----
`timescale 1ns/1ps
module nvreg_status_monitor
(
    input wire logic       i_clk,
    input wire logic       i_rst,
    input wire logic       i_por,
    input wire logic       i_cs_n,
    input wire logic [7:0] o_live_status,
    input wire logic [7:0] o_nv_status
);
    logic [7:0] busy_cnt_ff;
    logic [7:0] nxt_busy_cnt;
    always_comb nxt_busy_cnt = o_live_status[0] ? busy_cnt_ff + 8'h01 : 8'h00;
    always_ff @(posedge i_clk) busy_cnt_ff <= nxt_busy_cnt;
    default clocking @(posedge i_clk); endclocking
    default disable iff (i_rst || i_por);
    sequence s_write_end;
        $fell(o_live_status[0]);
    endsequence
    chk_ro_bits: assert property (o_nv_status[1:0] == 2'h0)
        else $error("nv read-only bits moved");
    chk_por_ship: assert property (@(posedge i_clk) disable iff (i_rst)
        i_por ##1 i_por |=> o_nv_status == 8'h00) else $error("por left nv byte set");
    chk_rst_reload: assert property ($fell(i_rst) |-> ##[1:2] o_live_status == o_nv_status)
        else $error("live copy not reloaded");
    chk_nv_write_only: assert property (!$stable(o_nv_status)
        |-> $past(o_live_status[0]) || $past(o_live_status[0], 2)) else $error("nv moved idle");
    chk_busy_span: assert property (s_write_end |-> busy_cnt_ff >= 8'h78)
        else $error("erase and program too short");
    chk_write_refresh: assert property (s_write_end |-> ##[0:2]
        (o_live_status[7:2] == o_nv_status[7:2] && !o_live_status[1])) else $error("no refresh");
    chk_latch_in_frame: assert property ($rose(o_live_status[1]) |-> !i_cs_n)
        else $error("latch set outside frame");
    chk_write_latched: assert property ($rose(o_live_status[0]) |-> $past(o_live_status[1]))
        else $error("write ran without latch");
endmodule
bind nv_shadow_status_register nvreg_status_monitor mon_u (.i_clk(i_clk), .i_rst(i_rst),
    .i_por(i_por), .i_cs_n(i_cs_n), .o_live_status(o_live_status), .o_nv_status(o_nv_status));

// ---- tb/nvreg_spi_host.sv ----
`timescale 1ns/1ps
module nvreg_spi_host
    import nvreg_pkg::*;
(
    input  wire logic  i_clk,
    input  wire logic  i_so,
    output logic       o_sck,
    output logic       o_cs_n,
    output logic       o_si,
    output logic       o_rd_stb,
    output logic [7:0] o_rd_byte
);
    initial
    begin
        {o_sck, o_cs_n, o_si, o_rd_stb, o_rd_byte} = 12'h400;
    end
    // Deselected data line toggles so no stale bit looks valid
    always @(negedge i_clk) if (o_cs_n) o_si <= ~o_si;
    task automatic shift(input logic [7:0] tx, input logic rd);
        for (int i = 7; i >= 0; i--)
        begin
            @(negedge i_clk) o_si = tx[i];
            repeat (6) @(negedge i_clk);
            o_rd_byte[i] = i_so;
            o_sck = 1'b1;
            repeat (6) @(negedge i_clk);
            o_sck = 1'b0;
        end
        o_rd_stb = rd;
    endtask
    task automatic frame(input logic [7:0] cmd, input logic [23:0] addr,
                         input logic [7:0] data, input logic [1:0] mode);
        @(negedge i_clk) o_cs_n = 1'b0;
        shift(cmd, 1'b0);
        if (cmd == CMD_ADDR_REG_READ || cmd == CMD_ADDR_REG_WRITE)
            for (int i = 2; i >= 0; i--) shift(addr[8*i +: 8], 1'b0);
        if (mode != 2'h0) shift(data, mode[1]);
        repeat (6) @(negedge i_clk);
        {o_cs_n, o_rd_stb} = 2'b10;
        repeat (8) @(negedge i_clk);
    endtask
endmodule

// ---- tb/nv_shadow_status_register_tb.sv ----
`timescale 1ns/1ps
module nv_shadow_status_register_tb
    import nvreg_pkg::*;
;
    logic       i_clk, i_rst, i_por, sck, cs_n, si, so, stb;
    logic [7:0] live, nv, rd_byte, a, b;
    logic [7:0] exp_q[$];
    int         n_mismatch = 0, compares = 0;
    nv_shadow_status_register dut_u (.i_clk(i_clk), .i_rst(i_rst), .i_por(i_por), .i_sck(sck),
        .i_cs_n(cs_n), .i_si(si), .o_so(so), .o_live_status(live), .o_nv_status(nv));
    nvreg_spi_host host_u (.i_clk(i_clk), .i_so(so), .o_sck(sck), .o_cs_n(cs_n), .o_si(si),
        .o_rd_stb(stb), .o_rd_byte(rd_byte));
    initial
    begin
        i_clk = 1'b0;
        forever #12.5 i_clk = ~i_clk;
    end
    task automatic check_byte(input logic [7:0] got, input logic [7:0] exp);
        compares++;
        if (got !== exp) $display("FAIL t=%0t got %h want %h", $time, got, exp);
        if (got !== exp) n_mismatch++;
    endtask
    always @(posedge stb) check_byte(rd_byte, exp_q.pop_front());
    task automatic rd(input logic [7:0] c, input logic [23:0] ad, input logic [7:0] e);
        exp_q.push_back(e);
        host_u.frame(c, ad, 8'h00, 2'h2);
    endtask
    task automatic wr(input logic [7:0] c, input logic [23:0] ad, input logic [7:0] d);
        host_u.frame(CMD_SET_WRITE_LATCH, 24'h0, 8'h0, 2'h0);
        host_u.frame(c, ad, d, 2'h1);
        for (int k = 0; k < 400 && live[0] !== 1'b0; k++) @(negedge i_clk);
        repeat (4) @(negedge i_clk);
    endtask
    task automatic pulse(input logic por);
        {i_rst, i_por} = {~por, por};
        repeat (10) @(negedge i_clk);
        {i_rst, i_por} = 2'b00;
        repeat (4) @(negedge i_clk);
    endtask
    task automatic give_verdict();
        $display("compares %0d mismatches %0d", compares, n_mismatch);
        if (n_mismatch == 0 && compares > 0) $display("STATUS OK");
        else $display("STATUS NOT OK");
        $finish;
    endtask
    initial
    begin
        void'($urandom(32'h9556242e));
        pulse(1'b1);
        a = 8'($urandom) & STATUS_ONE_USER_MSK;
        b = ~a & STATUS_ONE_USER_MSK;
        rd(CMD_STATUS_ONE_READ, 24'h0, STATUS_ONE_NV_SHIP);
        rd(CMD_ADDR_REG_READ, 24'h000001, UNMAPPED_READ_VALUE);
        host_u.frame(CMD_LEGACY_REG_WRITE, 24'h0, ~a, 2'h1);
        rd(CMD_ADDR_REG_READ, ADDR_STATUS_ONE_NV, STATUS_ONE_NV_SHIP);
        host_u.frame(CMD_SET_WRITE_LATCH, 24'h0, 8'h0, 2'h0);
        check_byte(live, 8'h02);
        host_u.frame(CMD_CLR_WRITE_LATCH, 24'h0, 8'h0, 2'h0);
        check_byte(live, 8'h00);
        wr(CMD_LEGACY_REG_WRITE, 24'h0, ~a);
        check_byte(live, b);
        wr(CMD_ADDR_REG_WRITE, ADDR_STATUS_ONE_NV, a | 8'h03);
        check_byte(nv, a);
        rd(CMD_ADDR_REG_READ, ADDR_STATUS_ONE_NV, a);
        wr(CMD_ADDR_REG_WRITE, ADDR_STATUS_ONE_LIVE, b);
        rd(CMD_STATUS_ONE_READ, 24'h0, b);
        rd(CMD_ADDR_REG_READ, ADDR_STATUS_ONE_NV, a);
        pulse(1'b0);
        rd(CMD_STATUS_ONE_READ, 24'h0, a);
        wr(CMD_ADDR_REG_WRITE, ADDR_STATUS_ONE_LIVE, b);
        host_u.frame(CMD_SOFT_RESET, 24'h0, 8'h0, 2'h0);
        rd(CMD_ADDR_REG_READ, ADDR_STATUS_ONE_LIVE, a);
        pulse(1'b1);
        rd(CMD_STATUS_ONE_READ, 24'h0, STATUS_ONE_NV_SHIP);
        give_verdict();
    end
    initial
    begin
        repeat (40000) @(posedge i_clk);
        n_mismatch++;
        give_verdict();
    end
endmodule
